// [inc/stpw_pkg.sv]
// Package with register map, field positions and constants of the timer block
package stpw_pkg;
  // ==================================================
  // Register byte offsets
  localparam logic [11:0] STPW_CTRL_OFS = 12'h000;
  localparam logic [11:0] STPW_COMPARE_A_VALUE_OFS = 12'h004;
  localparam logic [11:0] STPW_PERIOD_COMPARE_VALUE_OFS = 12'h008;
  localparam logic [11:0] STPW_CNT_OFS = 12'h00c;
  localparam logic [11:0] STPW_STAT_OFS = 12'h010;
  // ==================================================
  // Control field positions
  localparam int STPW_ON_BIT = 0;
  localparam int STPW_CCLR_BIT = 1;
  localparam int STPW_DPX_BIT = 2;
  localparam int STPW_POL_BIT = 3;
  localparam int STPW_OC_BIT = 4;
  localparam int STPW_IO_LO = 5;
  localparam int STPW_MODE_LO = 7;
  localparam int STPW_EXT_RISE_BIT = 9;
  // Status field positions
  localparam int STPW_AF_BIT = 0;
  localparam int STPW_PF_BIT = 1;
  // ==================================================
  // Mode and pin function codes
  localparam logic [1:0] STPW_MODE_CMP = 2'h0;
  localparam logic [1:0] STPW_MODE_CAP = 2'h1;
  localparam logic [1:0] STPW_MODE_PWM = 2'h2;
  localparam logic [1:0] STPW_IO_INACT = 2'h0;
  localparam logic [1:0] STPW_IO_ACT = 2'h1;
  localparam logic [1:0] STPW_IO_PWM = 2'h2;
  localparam logic [1:0] STPW_IO_PULSE = 2'h3;
  localparam logic [1:0] STPW_CAP_RISE = 2'h0;
  localparam logic [1:0] STPW_CAP_FALL = 2'h1;
  localparam logic [1:0] STPW_CAP_BOTH = 2'h2;
  // ==================================================
  // Widths and reset values
  localparam int STPW_CW = 16;
  localparam logic [9:0] STPW_CTRL_RST = 10'h000;
  // Timer clock divider (timer clock = mclk / this)
  localparam logic [3:0] STPW_DIV = 4'h4;
endpackage

// [hdl/stpw_clkdiv.sv]
// Timer clock enable divider
`timescale 1ns/1ns
module stpw_clkdiv (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Tick output
  output logic tick_o
);
  import stpw_pkg::*;
  typedef struct packed {
    logic [3:0] cnt;
    logic tick;
  } stpw_div_t;
  stpw_div_t s_q, s_d;
  // ==================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == STPW_DIV - 4'h1) begin
      s_d.cnt = 4'h0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 4'h1;
    end
  end
  // Register
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign tick_o = s_q.tick;
endmodule

// [hdl/stpw_timer.sv]
// Standard timer: PWM, single pulse and capture modes with APB registers
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
// Operation
// - Swap bit picks period and duty register
// - Clear select ignored in PWM mode
// - Separate flags for A and P matches
// - Level bit polarity; pin bits force/enable
// - Invert bit inverts the output pin
// - 10-bit period is P times 128, zero 1024
// - 16-bit period is P times 256, zero 65536
// - Swap set: A period, P scaled duty
// - Duty at or above period gives 100%
// - Counting continues while output forced
// - On bit rising starts counter and pulse
// - External clock pin edge sets on bit
// - A match clears on bit, ends pulse
// - Pulse counter cleared only by on rising
// - Capture edge latches counter into compare A
// - Pin bits select edge; 11 disables capture
// - Free run; P match wraps and flags
// - P zero lets counter reach maximum
// - Capture mode drives no output
module stpw_timer #(
  parameter bit WIDE = 1'b1 // 1: 16-bit instance, 0: 10-bit
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Pins
  input wire logic ext_clock_pin_i,
  input wire logic capture_pin_i,
  output logic timer_out_o,
  output logic timer_irq_o
);
  import stpw_pkg::*;
  typedef struct packed {
    logic [9:0] ctrl;
    logic [15:0] compare_a_value;
    logic [7:0] period_compare_value;
    logic [15:0] cnt;
    logic [1:0] flags;
    logic on_prev;
    logic ext_prev;
    logic cap_prev;
    logic pwm_act;
    logic pin;
    logic irq;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
  } stpw_state_t;
  stpw_state_t s_q, s_d;
  logic tick;
  // Divided timer clock
  stpw_clkdiv u_div (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .tick_o(tick)
  );
  // ==================================================
  // Field views
  logic on_b, dpx_b, pol_b, oc_b, ext_rise_b;
  logic [1:0] io_f, mode_f;
  assign on_b = s_q.ctrl[STPW_ON_BIT];
  assign dpx_b = s_q.ctrl[STPW_DPX_BIT];
  assign pol_b = s_q.ctrl[STPW_POL_BIT];
  assign oc_b = s_q.ctrl[STPW_OC_BIT];
  assign io_f = s_q.ctrl[STPW_IO_LO +: 2];
  assign mode_f = s_q.ctrl[STPW_MODE_LO +: 2];
  assign ext_rise_b = s_q.ctrl[STPW_EXT_RISE_BIT];
  // ==================================================
  // Scaled compare values
  logic [16:0] p_scaled, a_val, per_len, duty_len, cmax;
  always_comb begin
    if (WIDE) begin
      p_scaled = (s_q.period_compare_value == 8'h00) ? 17'h10000 : {1'b0, s_q.period_compare_value, 8'h00};
      a_val = {1'b0, s_q.compare_a_value};
      cmax = 17'h0ffff;
    end else begin
      p_scaled = (s_q.period_compare_value[2:0] == 3'h0) ? 17'h00400 : {7'h00, s_q.period_compare_value[2:0], 7'h00};
      a_val = {7'h00, s_q.compare_a_value[9:0]};
      cmax = 17'h003ff;
    end
    if (dpx_b) begin
      per_len = a_val;
      duty_len = p_scaled;
    end else begin
      per_len = p_scaled;
      duty_len = a_val;
    end
  end
  // Match detection on current count
  logic [16:0] cnt_x;
  logic a_hit, p_hit, cap_edge;
  assign cnt_x = {1'b0, s_q.cnt};
  assign a_hit = (cnt_x == a_val);
  // zero P compares at the maximum count
  assign p_hit = (p_scaled > cmax) ? (cnt_x == cmax) : (cnt_x + 17'h1 == p_scaled);
  always_comb begin
    unique case (io_f)
      STPW_CAP_RISE: cap_edge = capture_pin_i & ~s_q.cap_prev;
      STPW_CAP_FALL: cap_edge = ~capture_pin_i & s_q.cap_prev;
      STPW_CAP_BOTH: cap_edge = capture_pin_i ^ s_q.cap_prev;
      default: cap_edge = 1'b0;
    endcase
  end
  // ==================================================
  // APB decode
  logic acc, wr;
  assign acc = psel_i & penable_i & ~s_q.ready;
  assign wr = acc & pwrite_i;
  // ==================================================
  // Next state
  always_comb begin
    logic ev_a, ev_p, set_on, clr_on, rise_on, raw;
    s_d = s_q;
    ev_a = 1'b0;
    ev_p = 1'b0;
    set_on = 1'b0;
    clr_on = 1'b0;
    raw = 1'b0;
    rise_on = on_b & ~s_q.on_prev;
    s_d.ready = acc;
    s_d.slverr = 1'b0;
    s_d.ext_prev = ext_clock_pin_i;
    s_d.cap_prev = capture_pin_i;
    s_d.on_prev = on_b;
    // Counter, on timer ticks
    if (rise_on) begin
      s_d.cnt = 16'h0000;
      s_d.pwm_act = 1'b1;
    end else if (on_b && tick) begin
      unique case (mode_f)
        STPW_MODE_PWM: begin
          if (io_f == STPW_IO_PULSE) begin
            if (a_hit) begin
              ev_a = 1'b1;
              clr_on = 1'b1;
            end else begin
              s_d.cnt = s_q.cnt + 16'h1;
            end
          end else begin
            if (cnt_x + 17'h1 >= per_len) begin
              s_d.cnt = 16'h0000;
            end else begin
              s_d.cnt = s_q.cnt + 16'h1;
            end
            ev_a = a_hit;
            ev_p = (cnt_x + 17'h1 == p_scaled);
          end
        end
        STPW_MODE_CAP: begin
          if (p_hit) begin
            s_d.cnt = 16'h0000;
            ev_p = 1'b1;
          end else begin
            s_d.cnt = s_q.cnt + 16'h1;
          end
        end
        default: s_d.cnt = s_q.cnt + 16'h1;
      endcase
    end
    // PWM active phase: next count below duty; full duty
    if (mode_f == STPW_MODE_PWM && io_f != STPW_IO_PULSE && on_b) begin
      s_d.pwm_act = ({1'b0, s_d.cnt} < duty_len) || (duty_len >= per_len);
    end
    if (mode_f == STPW_MODE_CAP && on_b && cap_edge) begin
      s_d.compare_a_value = WIDE ? s_q.cnt : {6'h00, s_q.cnt[9:0]};
      ev_a = 1'b1;
    end
    if (mode_f == STPW_MODE_PWM && io_f == STPW_IO_PULSE && !on_b &&
        (ext_rise_b ? (ext_clock_pin_i & ~s_q.ext_prev)
                    : (~ext_clock_pin_i & s_q.ext_prev))) begin
      set_on = 1'b1;
    end
    // Register writes
    if (wr) begin
      unique case (paddr_i)
        STPW_CTRL_OFS: s_d.ctrl = pwdata_i[9:0];
        STPW_COMPARE_A_VALUE_OFS: s_d.compare_a_value = WIDE ? pwdata_i[15:0] : {6'h00, pwdata_i[9:0]};
        STPW_PERIOD_COMPARE_VALUE_OFS: s_d.period_compare_value = pwdata_i[7:0];
        STPW_STAT_OFS: s_d.flags = s_q.flags & ~pwdata_i[1:0];
        default: s_d.slverr = 1'b1;
      endcase
    end
    if (acc && !pwrite_i) begin
      unique case (paddr_i)
        STPW_CTRL_OFS: s_d.rdata = {22'h0, s_q.ctrl};
        STPW_COMPARE_A_VALUE_OFS: s_d.rdata = {16'h0, s_q.compare_a_value};
        STPW_PERIOD_COMPARE_VALUE_OFS: s_d.rdata = {24'h0, s_q.period_compare_value};
        STPW_CNT_OFS: s_d.rdata = {16'h0, s_q.cnt};
        STPW_STAT_OFS: s_d.rdata = {30'h0, s_q.flags};
        default: begin
          s_d.rdata = 32'h0;
          s_d.slverr = 1'b1;
        end
      endcase
    end
    // Hardware set wins over software clear
    if (set_on) s_d.ctrl[STPW_ON_BIT] = 1'b1;
    if (clr_on) s_d.ctrl[STPW_ON_BIT] = 1'b0;
    if (ev_a) s_d.flags[STPW_AF_BIT] = 1'b1;
    if (ev_p) s_d.flags[STPW_PF_BIT] = 1'b1;
    s_d.irq = |s_d.flags;
    // Output pin
    if (mode_f == STPW_MODE_PWM) begin
      unique case (io_f)
        STPW_IO_INACT: raw = ~oc_b;
        STPW_IO_ACT: raw = oc_b;
        STPW_IO_PWM: raw = s_d.pwm_act ? oc_b : ~oc_b;
        default: raw = s_d.ctrl[STPW_ON_BIT] ? oc_b : ~oc_b;
      endcase
      s_d.pin = raw ^ pol_b;
    end else begin
      s_d.pin = 1'b0;
    end
  end
  // Register
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
      s_q.ctrl <= STPW_CTRL_RST;
    end else begin
      s_q <= s_d;
    end
  end
  assign prdata_o = s_q.rdata;
  assign pready_o = s_q.ready;
  assign pslverr_o = s_q.slverr;
  assign timer_out_o = s_q.pin;
  assign timer_irq_o = s_q.irq;
  // ==================================================
  // Checks
  // On-bit rising seen by the checks
  logic rise_on_w;
  assign rise_on_w = on_b & ~s_q.on_prev;
  // A match in pulse mode clears on
  AST_PULSE_END: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode_f == STPW_MODE_PWM && io_f == STPW_IO_PULSE && on_b && tick && a_hit && !rise_on_w)
    |=> !on_b ##1 s_q.flags[STPW_AF_BIT]) else $error("pulse not ended by A match");
  AST_ON_RISE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    rise_on_w |=> s_q.cnt == 16'h0000) else $error("counter not cleared on start");
  AST_CAPTURE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode_f == STPW_MODE_CAP && on_b && cap_edge && !wr)
    |=> s_q.compare_a_value[9:0] == $past(s_q.cnt[9:0]) && s_q.flags[STPW_AF_BIT])
    else $error("capture failed");
  AST_CAP_OFF: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode_f == STPW_MODE_CAP && io_f == 2'h3 && !wr) |=> $stable(s_q.compare_a_value))
    else $error("capture while disabled");
  AST_CAP_NOOUT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    mode_f == STPW_MODE_CAP |=> !timer_out_o) else $error("output in capture mode");
  AST_CAP_WRAP: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode_f == STPW_MODE_CAP && on_b && tick && p_hit && !rise_on_w)
    |=> s_q.cnt == 16'h0000 ##1 s_q.flags[STPW_PF_BIT]) else $error("no wrap");
  AST_FORCED_RUN: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode_f == STPW_MODE_PWM && io_f == STPW_IO_INACT && on_b && tick && !rise_on_w
     && cnt_x + 17'h1 < per_len) |=> s_q.cnt == $past(s_q.cnt) + 16'h1)
    else $error("counter stalled");
  AST_FORCE_ACT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mode_f == STPW_MODE_PWM && io_f == STPW_IO_ACT && !wr) |=> timer_out_o == (oc_b ^ pol_b))
    else $error("forced level wrong");
  COV_PULSE: cover property (@(posedge mclk_i) rise_on_w && io_f == STPW_IO_PULSE);
  COV_CAP: cover property (@(posedge mclk_i) mode_f == STPW_MODE_CAP && cap_edge && on_b);
  COV_PWM: cover property (@(posedge mclk_i) mode_f == STPW_MODE_PWM && $rose(timer_out_o));
endmodule

// [testbench/stpw_pin_model.sv]
// Model of the circuitry on the clock, capture and output pins
`timescale 1ns/1ns
module stpw_pin_model (
  // Clock
  input wire logic mclk_i,
  // Output pin seen by the load
  input wire logic timer_out_i,
  // Pins driven by the far side
  output logic ext_clock_pin_o,
  output logic capture_pin_o
);
  // ====
  // Idle levels from time zero
  initial begin
    ext_clock_pin_o = 1'b0;
    capture_pin_o = 1'b0;
  end
  // Move the capture pin and hold it long enough to be synchronised
  task automatic cap_edge(input logic lvl);
    @(posedge mclk_i);
    capture_pin_o <= lvl;
    repeat (8) @(posedge mclk_i);
  endtask
  // One rising then falling edge on the clock pin
  task automatic ext_pulse();
    @(posedge mclk_i);
    ext_clock_pin_o <= 1'b1;
    repeat (8) @(posedge mclk_i);
    ext_clock_pin_o <= 1'b0;
  endtask
  // Count the cycles the output pin is high within a window
  task automatic measure(input int n, output int hi);
    hi = 0;
    repeat (n) begin
      @(posedge mclk_i);
      if (timer_out_i === 1'b1) begin
        hi++;
      end
    end
  endtask
endmodule

// [testbench/std_timer_pwm_pulse_capture_bench.sv]
// Self-checking bench of the timer: registers, capture, PWM and single pulse
`timescale 1ns/1ns
module std_timer_pwm_pulse_capture_bench;
  import stpw_pkg::*;
  // ====
  // Signals
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ext_pin;
  logic cap_pin;
  logic tout;
  logic irq;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [15:0] ra;
  int err_count = 0;
  int checked = 0;
  int hi;
  // Control bit masks
  localparam logic [31:0] ON = 32'h1 << STPW_ON_BIT;
  localparam logic [31:0] CCLR = 32'h1 << STPW_CCLR_BIT;
  localparam logic [31:0] DPX = 32'h1 << STPW_DPX_BIT;
  localparam logic [31:0] POL = 32'h1 << STPW_POL_BIT;
  localparam logic [31:0] OC = 32'h1 << STPW_OC_BIT;
  localparam logic [31:0] EXT = 32'h1 << STPW_EXT_RISE_BIT;
  // ====
  // Clock, design and pin model
  always #5 mclk = ~mclk;
  stpw_timer dut (.mclk_i(mclk), .sys_rst_i(rst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .ext_clock_pin_i(ext_pin),
    .capture_pin_i(cap_pin), .timer_out_o(tout), .timer_irq_o(irq));
  stpw_pin_model pins (.mclk_i(mclk), .timer_out_i(tout), .ext_clock_pin_o(ext_pin),
    .capture_pin_o(cap_pin));
  // ====
  // Tasks
  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // APB transfer; the note holds {compare data, error, data}
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [33:0] x);
    int n;
    n = 0;
    @(posedge mclk);
    exp_q.push_back(x);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      err_count++;
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 34'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, {2'b10, x});
  endtask
  function automatic logic [31:0] cw(input logic [1:0] m, input logic [1:0] io,
    input logic [31:0] x);
    cw = ({30'h0, m} << STPW_MODE_LO) | ({30'h0, io} << STPW_IO_LO) | x;
  endfunction
  // One PWM setting, switched off first, then high time over a window
  task automatic pwm(input logic [15:0] a, input logic [1:0] io, input logic [31:0] x,
    input int win, input int eh);
    wr(STPW_CTRL_OFS, 32'h0);
    wr(STPW_COMPARE_A_VALUE_OFS, {16'h0, a});
    wr(STPW_STAT_OFS, 32'h3);
    wr(STPW_CTRL_OFS, cw(STPW_MODE_PWM, io, x | ON | OC));
    repeat (1100) @(posedge mclk);
    pins.measure(win, hi);
    chk(hi == eh, "pwm high count");
  endtask
  // ====
  // Answer monitor: oldest note against each answer
  always @(posedge mclk) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(1'b0, "answer without request");
      end else begin
        e = exp_q.pop_front();
        chk(pslverr === e[32] && (!e[33] || prdata === e[31:0]), "apb answer");
      end
    end
  end
  // ====
  // Main sequence
  initial begin
    void'($urandom(32'h7d7d));
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    // Reset values, unmapped read, write to read-only counter
    for (int i = 0; i < 5; i++) rd(12'(4 * i), 32'h0);
    apb(1'b0, 12'h014, 32'h0, {2'b11, 32'h0});
    apb(1'b1, STPW_CNT_OFS, 32'h5, {2'b01, 32'h0});
    // Capture mode wrap flag
    wr(STPW_PERIOD_COMPARE_VALUE_OFS, 32'h1);
    wr(STPW_CTRL_OFS, cw(STPW_MODE_CAP, 2'h3, ON | OC));
    repeat (880) @(posedge mclk);
    rd(STPW_STAT_OFS, 32'h0);
    repeat (250) @(posedge mclk);
    rd(STPW_STAT_OFS, 32'h2);
    chk(irq === 1'b1, "irq level");
    // Capture edge codes
    for (int m = 0; m < 4; m++) begin
      wr(STPW_CTRL_OFS, 32'h0);
      wr(STPW_COMPARE_A_VALUE_OFS, 32'h1234);
      wr(STPW_STAT_OFS, 32'h3);
      wr(STPW_CTRL_OFS, cw(STPW_MODE_CAP, m[1:0], ON | OC | POL));
      pins.cap_edge(1'b1);
      rd(STPW_STAT_OFS, {31'h0, m == 0 || m == 2});
      wr(STPW_STAT_OFS, 32'h3);
      pins.cap_edge(1'b0);
      rd(STPW_STAT_OFS, {31'h0, m == 1 || m == 2});
      if (m == 3) rd(STPW_COMPARE_A_VALUE_OFS, 32'h1234);
      chk(tout === 1'b0, "capture drove pin");
    end
    // PWM settings
    ra = 16'($urandom_range(255, 1));
    pwm(ra, STPW_IO_PWM, 32'h0, 1024, ra * 4);
    pwm(ra, STPW_IO_PWM, CCLR, 1024, ra * 4);
    pwm(ra, STPW_IO_PWM, POL, 1024, 1024 - ra * 4);
    pwm(16'h100, STPW_IO_PWM, 32'h0, 1024, 1024);
    pwm(16'h200, STPW_IO_PWM, DPX, 2048, 1024);
    pwm(ra, STPW_IO_ACT, 32'h0, 1024, 1024);
    pwm(ra, STPW_IO_INACT, 32'h0, 1024, 0);
    rd(STPW_STAT_OFS, 32'h3);
    // Single pulse from the clock pin, then from software
    for (int t = 0; t < 2; t++) begin
      wr(STPW_CTRL_OFS, 32'h0);
      wr(STPW_COMPARE_A_VALUE_OFS, 32'h10);
      wr(STPW_STAT_OFS, 32'h3);
      wr(STPW_CTRL_OFS, cw(STPW_MODE_PWM, STPW_IO_PULSE, OC | EXT));
      fork
        pins.measure(200, hi);
        if (t == 0) pins.ext_pulse();
        else wr(STPW_CTRL_OFS, cw(STPW_MODE_PWM, STPW_IO_PULSE, OC | EXT | ON));
      join
      chk(hi >= 60 && hi <= 70, "pulse width");
      rd(STPW_CTRL_OFS, cw(STPW_MODE_PWM, STPW_IO_PULSE, OC | EXT));
      rd(STPW_STAT_OFS, 32'h1);
    end
    repeat (3) @(posedge mclk);
    wrap_up();
  end
endmodule
